// >>> fpec_flash_ctrl.sv
// fpec_flash_ctrl: register blocks, address decode and program/erase interlocks for two flash arrays
// assumes: the flash cell macros sit outside and act on the strobes and levels driven here;
// mode inputs and the cpu array bus come from logic on pclk, so they pass no synchroniser
// Overview of operation
// [R1] 8K boot region at top of each array
// [R2] each array has its own 4-byte block; the code gives each array four 32-bit word slots (16 bytes)
// [R3] fixed array ranges; both off when expanded
// [R4] lock latch written once in normal modes
// [R5] lock set blocks config register writes
// [R6] boot protect locked by latch or select
// [R7] boot protect one forbids boot region changes
// [R8] halt bit stops module clock in wait
// [R9] high voltage only after select and latch
// [R10] high voltage bit drives the charge pump
// [R11] program and erase selects never both set
// [R12] misaligned word read takes one extra cycle
// [R13] bus writes never alter array contents
// [R14] program clears bits, erase sets all ones
// [R15] only aligned words are programmed
// [R16] erase covers the whole array only
// [R17] software keeps order, pulse under 40 us
// [R18] software runs sequence outside that flash
// [R19] software erases fully before final data
// [R20] array supplies reset vector in single chip
// [R21] software program row step order
// [R22] boot region words ignored while protected
// [R23] software erase step order
// [R24] stop or wait aborts program and erase
// [R25] unused register bits read zero
// [R26] no internal timing of phases
`timescale 1ns/1ps
`default_nettype none

module fpec_flash_ctrl (
  input  wire logic                               pclk,             // bus clock
  input  wire logic                               presetn,          // async reset, active low
  input  wire logic                               psel,             // apb select
  input  wire logic                               penable,          // apb access phase
  input  wire logic                               pwrite,           // apb direction
  input  wire logic [fpec_pkg::APB_ADDR_W-1:0]    paddr,            // apb byte address
  input  wire logic [31:0]                        pwdata,           // apb write data
  output logic [31:0]                             prdata,           // apb read data
  output logic                                    pready,           // apb ready
  output logic                                    pslverr,          // unmapped address
  input  wire logic                               normal_mode,      // normal (not special) mode
  input  wire logic                               expanded_mode,    // expanded bus mode
  input  wire logic                               wait_mode,        // chip in wait
  input  wire logic                               stop_mode,        // chip in stop
  input  wire logic                               cpu_valid,        // cpu array access
  input  wire logic                               cpu_write,        // cpu access is a write
  input  wire logic                               cpu_byte,         // byte_size_indicator
  input  wire logic [15:0]                        cpu_addr,         // cpu address
  input  wire logic [15:0]                        cpu_wdata,        // cpu write data
  output logic                                    cpu_wait,         // stretch misaligned read
  output logic [1:0]                              array_read_sel,   // read select per array
  output logic [1:0]                              array_clk_en,     // module clock enable
  output logic [1:0]                              pump_on,          // charge pump and high voltage
  output logic [1:0]                              prog_strobe,      // program one word
  output logic [15:0]                             prog_addr,        // word address to program
  output logic [15:0]                             prog_data,        // zeros clear cells
  output logic [1:0]                              erase_on,         // bulk erase active
  output logic [1:0]                              erase_boot        // erase includes boot region
);
  import fpec_pkg::*;

  fpec_state_t st_q;   // registered state
  fpec_state_t st_d;   // next state

  // address inside array a
  function automatic logic fpec_in_array(input int a, input logic [15:0] addr);
    if (a == 0) begin
      return (addr >= LARGE_BASE) && (addr <= LARGE_LAST);
    end
    return (addr >= SMALL_BASE) && (addr <= SMALL_LAST);
  endfunction : fpec_in_array

  // address inside the boot region of array a
  function automatic logic fpec_in_boot(input int a, input logic [15:0] addr);
    if (a == 0) begin
      return addr >= LARGE_BOOT_BASE;                                      // [R1]
    end
    return (addr >= SMALL_BOOT_BASE) && (addr <= SMALL_LAST);              // [R1]
  endfunction : fpec_in_boot

  // apb phases
  logic setup_ph;      // first cycle of a transfer
  logic wr_take;       // write takes effect this edge
  logic misaligned;    // misaligned word read in flight
  logic abort;         // low-power entry aborts sequences
  logic [1:0] hit;     // cpu address decodes to array

  assign setup_ph   = psel & ~penable;
  assign wr_take    = psel & penable & pwrite & st_q.rdy;
  assign misaligned = cpu_valid & ~cpu_write & ~cpu_byte & cpu_addr[0];
  assign abort      = wait_mode | stop_mode;                               // [R24]

  // array decode; the large array holds the reset vector in single-chip mode
  always_comb begin
    for (int a = 0; a < NUM_ARRAYS; a++) begin
      hit[a] = ~expanded_mode & fpec_in_array(a, cpu_addr);                // [R3] [R20]
    end
  end

  // next-state logic
  always_comb begin
    logic [1:0]  kind;     // register kind addressed
    logic        sel_small; // addressed block
    logic        mapped;   // address names a register
    logic [31:0] rval;     // read value
    logic        n_pgm;    // written program select
    logic        n_erase_select;   // written erase select
    logic        wr_arr;   // cpu write to this array
    fpec_arr_t   r;        // current array state
    kind   = KIND_LOCK;
    sel_small = 1'b0;
    mapped = 1'b0;
    rval   = 32'h0000_0000;
    n_pgm  = 1'b0;
    n_erase_select = 1'b0;
    wr_arr = 1'b0;
    r      = st_q.arr[0];
    st_d   = st_q;
    st_d.prog_strobe = 2'b00;

    // register decode, one aligned word each
    for (int a = 0; a < NUM_ARRAYS; a++) begin
      for (int k = 0; k < 3; k++) begin
        if (paddr == fpec_reg_addr(a[0], k[1:0])) begin                    // [R2]
          mapped = 1'b1;
          sel_small = a[0];
          kind   = k[1:0];
        end
      end
    end

    // read data captured in the setup cycle, so the access ends at once
    st_d.rdy = setup_ph;
    if (setup_ph) begin
      r = st_q.arr[sel_small];
      if (mapped) begin
        unique case (kind)
          KIND_LOCK: rval[LOCK_BIT]  = r.lock;                             // [R25]
          KIND_CFG:  rval[BOOT_REGION_PROTECT_BIT] = r.boot_region_protect;                            // [R25]
          default: begin
            rval[HALT_BIT] = r.halt;
            rval[HIGH_VOLTAGE_ENABLE_BIT] = r.high_voltage_enable;
            rval[ERASE_SELECT_BIT] = r.erase_select;
            rval[PGM_BIT]  = r.program_select;                                        // [R25]
          end
        endcase
      end
      st_d.rdata = rval;
    end

    for (int a = 0; a < NUM_ARRAYS; a++) begin
      r = st_q.arr[a];
      // register writes
      if (wr_take && mapped && sel_small == a[0]) begin
        unique case (kind)
          KIND_LOCK: begin
            // one write per reset in normal modes, free in special modes
            if (!normal_mode || !r.lock_written) begin                     // [R4]
              st_d.arr[a].lock         = pwdata[LOCK_BIT];
              st_d.arr[a].lock_written = 1'b1;
            end
          end
          KIND_CFG: begin
            // latch or an active select freezes boot protect
            if (!r.lock && !r.program_select && !r.erase_select) begin                        // [R5] [R6]
              st_d.arr[a].boot_region_protect = pwdata[BOOT_REGION_PROTECT_BIT];
            end
          end
          default: begin
            n_pgm  = pwdata[PGM_BIT];
            n_erase_select = pwdata[ERASE_SELECT_BIT];
            st_d.arr[a].halt = pwdata[HALT_BIT];
            // selects: a write of both is dropped, the other must be clear
            if (!(n_pgm && n_erase_select)) begin                                  // [R11]
              st_d.arr[a].program_select  = n_pgm & ~r.erase_select;                          // [R11]
              st_d.arr[a].erase_select = n_erase_select & ~r.program_select;                          // [R11]
            end
            // high voltage only after select and latch write
            if (!pwdata[HIGH_VOLTAGE_ENABLE_BIT]) begin
              st_d.arr[a].high_voltage_enable = 1'b0;
            end else if ((r.program_select || r.erase_select) && r.phase != PH_IDLE) begin    // [R9]
              st_d.arr[a].high_voltage_enable  = 1'b1;
              st_d.arr[a].phase = PH_HIGH_VOLTAGE;
            end
            // phases end only on software writes or stop/wait entry, never on a timer
            if (!pwdata[HIGH_VOLTAGE_ENABLE_BIT] && r.phase == PH_HIGH_VOLTAGE) begin     // [R26]
              st_d.arr[a].phase = PH_IDLE;
            end else if (!st_d.arr[a].program_select && !st_d.arr[a].erase_select && !st_d.arr[a].high_voltage_enable) begin
              st_d.arr[a].phase = PH_IDLE;
            end
          end
        endcase
      end

      // cpu writes: never stored, only latch or program under a select
      wr_arr = cpu_valid & cpu_write & hit[a];                             // [R13]
      if (wr_arr && (r.program_select || r.erase_select) && r.phase == PH_IDLE) begin
        st_d.arr[a].phase = PH_LATCHED;
      end
      if (wr_arr && r.program_select && r.high_voltage_enable && r.phase == PH_HIGH_VOLTAGE) begin
        // aligned words outside a protected boot region only
        if (!cpu_byte && !cpu_addr[0] && !(r.boot_region_protect && fpec_in_boot(a, cpu_addr))) begin // [R15] [R22] [R7]
          st_d.prog_strobe[a] = 1'b1;
          st_d.prog_addr      = cpu_addr;
          st_d.prog_data      = cpu_wdata;                                 // [R14]
        end
      end

      // stop or wait entry kills any sequence at once
      if (abort) begin                                                     // [R24]
        st_d.arr[a].program_select     = 1'b0;
        st_d.arr[a].erase_select    = 1'b0;
        st_d.arr[a].high_voltage_enable    = 1'b0;
        st_d.arr[a].phase   = PH_IDLE;
        st_d.prog_strobe[a] = 1'b0;
      end
    end

    // second cycle of a misaligned read
    st_d.mis_done = misaligned & ~st_q.mis_done;                           // [R12]
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.arr[0]      <= ARR_RESET;
      st_q.arr[1]      <= ARR_RESET;
      st_q.rdata       <= 32'h0000_0000;
      st_q.rdy         <= 1'b0;
      st_q.mis_done    <= 1'b0;
      st_q.prog_strobe <= 2'b00;
      st_q.prog_addr   <= 16'h0000;
      st_q.prog_data   <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  // apb answers: zero wait states, error on unmapped address
  always_comb begin
    logic m;   // access hits a register
    m = 1'b0;
    for (int a = 0; a < NUM_ARRAYS; a++) begin
      for (int k = 0; k < 3; k++) begin
        m = m | (paddr == fpec_reg_addr(a[0], k[1:0]));
      end
    end
    pready  = st_q.rdy;
    pslverr = psel & penable & st_q.rdy & ~m;
  end
  assign prdata = st_q.rdata;

  // array side outputs
  assign cpu_wait  = misaligned & ~st_q.mis_done;                          // [R12]
  assign prog_addr = st_q.prog_addr;
  assign prog_data = st_q.prog_data;
  assign prog_strobe = st_q.prog_strobe;
  always_comb begin
    for (int a = 0; a < NUM_ARRAYS; a++) begin
      array_read_sel[a] = hit[a] & cpu_valid & ~cpu_write;                 // [R13]
      array_clk_en[a]   = ~(wait_mode & st_q.arr[a].halt);                 // [R8]
      pump_on[a]        = st_q.arr[a].high_voltage_enable;                                // [R10]
      // bulk erase of the whole array; boot region kept while protected
      erase_on[a]       = st_q.arr[a].high_voltage_enable & st_q.arr[a].erase_select;             // [R16]
      erase_boot[a]     = st_q.arr[a].high_voltage_enable & st_q.arr[a].erase_select & ~st_q.arr[a].boot_region_protect; // [R7]
    end
  end

  // checks per array
  for (genvar g = 0; g < 2; g++) begin : g_chk
    property p_interlock;
      @(posedge pclk) disable iff (!presetn) !(st_q.arr[g].program_select && st_q.arr[g].erase_select);
    endproperty
    a_interlock: assert property (p_interlock) else $error("both selects set"); // [R11]

    property p_hv_order;
      @(posedge pclk) disable iff (!presetn)
        $rose(pump_on[g]) |-> $past(st_q.arr[g].phase) == PH_LATCHED && (st_q.arr[g].program_select || st_q.arr[g].erase_select);
    endproperty
    a_hv_order: assert property (p_hv_order) else $error("high voltage out of order"); // [R9]

    property p_lock_once;
      @(posedge pclk) disable iff (!presetn)
        normal_mode && st_q.arr[g].lock_written |=> $stable(st_q.arr[g].lock);
    endproperty
    a_lock_once: assert property (p_lock_once) else $error("lock rewritten"); // [R4]

    property p_cfg_frozen;
      @(posedge pclk) disable iff (!presetn)
        (st_q.arr[g].lock || st_q.arr[g].program_select || st_q.arr[g].erase_select) |=> $stable(st_q.arr[g].boot_region_protect);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("boot protect changed"); // [R5] [R6]

    property p_abort;
      @(posedge pclk) disable iff (!presetn) abort |=> !pump_on[g] && !prog_strobe[g] && !erase_on[g];
    endproperty
    a_abort: assert property (p_abort) else $error("sequence not aborted"); // [R24]

    property p_prog_legal;
      @(posedge pclk) disable iff (!presetn)
        prog_strobe[g] |-> !prog_addr[0] && !(st_q.arr[g].boot_region_protect && fpec_in_boot(g, prog_addr)) && pump_on[g];
    endproperty
    a_prog_legal: assert property (p_prog_legal) else $error("illegal word programmed"); // [R15] [R22]

    property p_halt;
      @(posedge pclk) disable iff (!presetn)
        wait_mode && st_q.arr[g].halt |-> !array_clk_en[g] ##1 (array_clk_en[g] || wait_mode);
    endproperty
    a_halt: assert property (p_halt) else $error("clock not halted"); // [R8]

    property p_expanded;
      @(posedge pclk) disable iff (!presetn) expanded_mode |-> !array_read_sel[g] ##1 !prog_strobe[g];
    endproperty
    a_expanded: assert property (p_expanded) else $error("array active in expanded mode"); // [R3]

    c_program: cover property (@(posedge pclk) disable iff (!presetn) prog_strobe[g]);
    c_erase:   cover property (@(posedge pclk) disable iff (!presetn) erase_on[g] && erase_boot[g]);
  end

  property p_misaligned;
    @(posedge pclk) disable iff (!presetn) misaligned && !st_q.mis_done |-> cpu_wait ##1 !cpu_wait;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned read not one extra cycle"); // [R12]

  c_misaligned: cover property (@(posedge pclk) disable iff (!presetn) cpu_wait ##1 !cpu_wait);

endmodule : fpec_flash_ctrl

`default_nettype wire

// >>> fpec_pkg.sv
// fpec_pkg: constants and types for the flash program/erase control block
// assumes: one bus clock, registers reached over apb with 32-bit data
package fpec_pkg;

  localparam int unsigned NUM_ARRAYS   = 2;        // large array 0, small array 1
  localparam int unsigned APB_ADDR_W   = 10;       // byte address width on apb

  // register indices; byte address is four times the index
  localparam logic [7:0]  LARGE_LOCK_IDX = 8'hf4;
  localparam logic [7:0]  LARGE_CFG_IDX  = 8'hf5;
  localparam logic [7:0]  LARGE_CTL_IDX  = 8'hf7;
  localparam logic [7:0]  SMALL_LOCK_IDX = 8'hf8;
  localparam logic [7:0]  SMALL_CFG_IDX  = 8'hf9;
  localparam logic [7:0]  SMALL_CTL_IDX  = 8'hfb;

  // register kinds inside one block of four 32-bit word slots (16 bytes)
  localparam logic [1:0]  KIND_LOCK = 2'h0;
  localparam logic [1:0]  KIND_CFG  = 2'h1;
  localparam logic [1:0]  KIND_CTL  = 2'h2;

  // field positions
  localparam int unsigned LOCK_BIT  = 0;
  localparam int unsigned BOOT_REGION_PROTECT_BIT = 0;
  localparam int unsigned PGM_BIT   = 0;
  localparam int unsigned ERASE_SELECT_BIT  = 1;
  localparam int unsigned HIGH_VOLTAGE_ENABLE_BIT  = 3;
  localparam int unsigned HALT_BIT  = 4;

  // values after reset
  localparam logic        LOCK_RESET  = 1'b0;
  localparam logic        BOOT_REGION_PROTECT_RESET = 1'b1;
  localparam logic        CTL_RESET   = 1'b0;

  // memory map of the arrays and boot regions
  localparam logic [15:0] LARGE_BASE      = 16'h8000;
  localparam logic [15:0] LARGE_LAST      = 16'hffff;
  localparam logic [15:0] SMALL_BASE      = 16'h1000;
  localparam logic [15:0] SMALL_LAST      = 16'h7fff;
  localparam logic [15:0] LARGE_BOOT_BASE = 16'he000;
  localparam logic [15:0] SMALL_BOOT_BASE = 16'h6000;
  localparam logic [15:0] RESET_VECTOR    = 16'hfffe;

  // sequence phase of one array
  typedef enum logic [1:0] {PH_IDLE, PH_LATCHED, PH_HIGH_VOLTAGE} fpec_phase_t;

  // control state of one array
  typedef struct packed {
    logic        lock;          // write protect latch
    logic        lock_written;  // lock already written since reset
    logic        boot_region_protect;         // boot_region_protect
    logic        halt;          // wait_mode_clock_halt
    logic        high_voltage_enable;          // high_voltage_enable
    logic        erase_select;          // erase_select
    logic        program_select;           // program_select
    fpec_phase_t phase;         // sequence progress
  } fpec_arr_t;

  localparam fpec_arr_t ARR_RESET = '{lock: LOCK_RESET, lock_written: 1'b0, boot_region_protect: BOOT_REGION_PROTECT_RESET,
                                      halt: CTL_RESET, high_voltage_enable: CTL_RESET, erase_select: CTL_RESET,
                                      program_select: CTL_RESET, phase: PH_IDLE};

  // whole block state
  typedef struct packed {
    fpec_arr_t [1:0] arr;          // per-array control
    logic [31:0]     rdata;        // apb read data
    logic            rdy;          // read data captured, access may end
    logic            mis_done;     // misaligned read second cycle
    logic [1:0]      prog_strobe;  // one-cycle word program strobe per array
    logic [15:0]     prog_addr;    // latched program address
    logic [15:0]     prog_data;    // latched program data
  } fpec_state_t;

  // byte address of a register from array and kind
  function automatic logic [APB_ADDR_W-1:0] fpec_reg_addr(input logic is_small, input logic [1:0] kind);
    logic [7:0] idx;
    idx = 8'h00;
    unique case (kind)
      KIND_LOCK: idx = is_small ? SMALL_LOCK_IDX : LARGE_LOCK_IDX;
      KIND_CFG:  idx = is_small ? SMALL_CFG_IDX  : LARGE_CFG_IDX;
      default:   idx = is_small ? SMALL_CTL_IDX  : LARGE_CTL_IDX;
    endcase
    return {idx, 2'b00};
  endfunction : fpec_reg_addr

endpackage : fpec_pkg

// >>> fpec_cpu_model.sv
// fpec_cpu_model: cpu side of the flash array bus, stepped by the bench through tasks
// assumes: pclk from the bench; every request starts just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module fpec_cpu_model (
  input  wire logic        pclk,           // bus clock
  output logic             cpu_valid,      // access this cycle
  output logic             cpu_write,      // write access
  output logic             cpu_byte,       // byte size access
  output logic [15:0]      cpu_addr,       // address
  output logic [15:0]      cpu_wdata,      // write data
  input  wire logic        cpu_wait,       // stretch request
  input  wire logic [1:0]  array_read_sel  // array answering
);
  // idle bus at time zero
  initial begin
    cpu_valid = 1'b0;
    cpu_write = 1'b0;
    cpu_byte  = 1'b0;
    cpu_addr  = 16'h0000;
    cpu_wdata = 16'h0000;
  end
  // one write cycle; the bench orders steps and runs from outside the array
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
    @(posedge pclk);
    cpu_valid <= 1'b1;
    cpu_write <= 1'b1;
    cpu_byte  <= b;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge pclk);
    cpu_valid <= 1'b0;
    cpu_addr  <= ~a;  // released lines show a changed pattern
    cpu_wdata <= ~d;
  endtask : wr
  // read; held a second cycle while the block stretches it
  task automatic rd(input logic [15:0] a, output logic ws, output logic [1:0] sel);
    @(posedge pclk);
    cpu_valid <= 1'b1;
    cpu_write <= 1'b0;
    cpu_byte  <= 1'b0;
    cpu_addr  <= a;
    @(posedge pclk);
    ws  = cpu_wait;
    sel = array_read_sel;
    if (ws) begin
      @(posedge pclk);
    end
    cpu_valid <= 1'b0;
    cpu_addr  <= ~a;
  endtask : rd
endmodule : fpec_cpu_model
`default_nettype wire

// >>> tb.sv
// tb: self-checking bench for fpec_flash_ctrl, apb master plus cpu model
// assumes: zero wait apb slave, registers at index times four
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpec_pkg::*;
  localparam logic [9:0] LK0 = {LARGE_LOCK_IDX, 2'b00};  // large lock
  localparam logic [9:0] CF0 = {LARGE_CFG_IDX, 2'b00};   // large config
  localparam logic [9:0] CT0 = {LARGE_CTL_IDX, 2'b00};   // large control
  localparam logic [9:0] LK1 = {SMALL_LOCK_IDX, 2'b00};  // small lock
  localparam logic [9:0] CF1 = {SMALL_CFG_IDX, 2'b00};   // small config
  localparam logic [9:0] CT1 = {SMALL_CTL_IDX, 2'b00};   // small control
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        normal_mode, expanded_mode, wait_mode, stop_mode;
  logic        cpu_valid, cpu_write, cpu_byte, cpu_wait, ws;
  logic [15:0] cpu_addr, cpu_wdata, prog_addr, prog_data, rw;
  logic [1:0]  array_read_sel, array_clk_en, pump_on, prog_strobe, erase_on, erase_boot, sel;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [32:0] rq[$];  // expected {pslverr, prdata}
  logic [33:0] pq[$];  // expected {strobe, addr, data}

  fpec_flash_ctrl i_fpec_flash_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .normal_mode, .expanded_mode, .wait_mode, .stop_mode, .cpu_valid,
    .cpu_write, .cpu_byte, .cpu_addr, .cpu_wdata, .cpu_wait, .array_read_sel, .array_clk_en,
    .pump_on, .prog_strobe, .prog_addr, .prog_data, .erase_on, .erase_boot);
  fpec_cpu_model i_fpec_cpu_model (.pclk, .cpu_valid, .cpu_write, .cpu_byte, .cpu_addr,
    .cpu_wdata, .cpu_wait, .array_read_sel);

  // count one comparison, report a miss
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // counts and verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      chk(1'b0, "no pready");
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read with the expected answer noted first
  task automatic rd(input logic [9:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    chk(1'b0, "timeout");
    finish_test();
  end
  // watcher: read answers and program strobes against the notes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rq.size() == 0) chk(1'b0, "unexpected read");
      else chk({pslverr, prdata} === rq.pop_front(), "register read");
    end
    if (prog_strobe !== 2'b00) begin
      if (pq.size() == 0) chk(1'b0, "unexpected program");
      else chk({prog_strobe, prog_addr, prog_data} === pq.pop_front(), "program word");
    end
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    normal_mode = 1'b1;
    expanded_mode = 1'b0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    rw = 16'($urandom(32'hc57d96d9));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    rd(LK0, 33'h0); rd(CF0, 33'h1); rd(CT0, 33'h0);
    rd(LK1, 33'h0); rd(CF1, 33'h1); rd(CT1, 33'h0);
    rd(10'h000, {1'b1, 32'h0});
    // config open, then lock once
    apb(1'b1, CF0, 32'hffff_fffe); rd(CF0, 33'h0);
    apb(1'b1, LK0, 32'h1); apb(1'b1, CF0, 32'h1); rd(CF0, 33'h0);
    apb(1'b1, LK0, 32'h0); rd(LK0, 33'h1);
    // interlocks on the control register
    apb(1'b1, CT0, 32'h3); rd(CT0, 33'h0);
    apb(1'b1, CT0, 32'h8); rd(CT0, 33'h0);
    // bulk erase of the large array, boot protect off
    apb(1'b1, CT0, 32'h2); apb(1'b1, CT0, 32'ha); rd(CT0, 33'h2);
    i_fpec_cpu_model.wr(16'h9000, rw, 1'b0);
    apb(1'b1, CT0, 32'ha); rd(CT0, 33'ha);
    chk(pump_on === 2'b01 && erase_on === 2'b01 && erase_boot === 2'b01, "erase");
    apb(1'b1, CT0, 32'hb); rd(CT0, 33'ha);
    apb(1'b1, CT0, 32'h8); rd(CT0, 33'h8);
    chk(erase_on === 2'b00 && pump_on === 2'b01, "erase end");
    apb(1'b1, CT0, 32'h0); rd(CT0, 33'h0);
    chk(pump_on === 2'b00, "pump off");
    // program the small array, boot protect on
    apb(1'b1, CT1, 32'h1); i_fpec_cpu_model.wr(16'h2000, rw, 1'b0);
    apb(1'b1, CT1, 32'h9); rd(CT1, 33'h9);
    chk(pump_on === 2'b10 && erase_on === 2'b00, "program voltage");
    rw = 16'($urandom);
    pq.push_back({2'b10, 16'h2002, rw});
    i_fpec_cpu_model.wr(16'h2002, rw, 1'b0);
    i_fpec_cpu_model.wr(16'h2005, rw, 1'b0);
    i_fpec_cpu_model.wr(16'h2004, rw, 1'b1);
    i_fpec_cpu_model.wr(16'h6000, rw, 1'b0);
    pq.push_back({2'b10, 16'h5ffe, ~rw});
    i_fpec_cpu_model.wr(16'h5ffe, ~rw, 1'b0);
    apb(1'b1, CT1, 32'h8); apb(1'b1, CT1, 32'h0); rd(CT1, 33'h0);
    i_fpec_cpu_model.wr(16'h2000, rw, 1'b0);
    // array reads
    i_fpec_cpu_model.rd(16'h9001, ws, sel);
    chk(ws === 1'b1 && sel === 2'b01, "misaligned read");
    i_fpec_cpu_model.rd(16'h2000, ws, sel);
    chk(ws === 1'b0 && sel === 2'b10, "aligned read");
    expanded_mode <= 1'b1;
    i_fpec_cpu_model.rd(16'h9000, ws, sel);
    chk(sel === 2'b00, "expanded off");
    expanded_mode <= 1'b0;
    // halt in wait and abort of a running erase
    apb(1'b1, CT1, 32'h10); apb(1'b1, CT0, 32'h2);
    i_fpec_cpu_model.wr(16'h8000, rw, 1'b0);
    apb(1'b1, CT0, 32'ha);
    wait_mode <= 1'b1;
    rd(CT0, 33'h0); rd(CT1, 33'h10);
    chk(array_clk_en === 2'b01 && pump_on === 2'b00, "wait halt");
    wait_mode <= 1'b0;
    // special mode lets the lock be rewritten
    normal_mode <= 1'b0;
    apb(1'b1, LK0, 32'h0); rd(LK0, 33'h0);
    chk(array_clk_en === 2'b11, "clock back");
    repeat (4) @(posedge pclk);
    chk(pq.size() == 0 && rq.size() == 0, "pending notes");
    finish_test();
  end
endmodule : tb
`default_nettype wire
